/* pkg/bpf_pkg.sv */
package bpf_pkg;
    localparam int BPF_CLK_HZ = 25_000_000;
    localparam int BPF_TICK_HZ = 4_000;
    localparam logic [12:0] BPF_TICK_DIV = 13'(BPF_CLK_HZ / BPF_TICK_HZ);
    // fixed detection delays, in 4 kHz ticks
    localparam logic [7:0] BPF_OVC_TICKS = 8'h10;
    localparam logic [7:0] BPF_OD_TICKS = 8'h10;
    localparam logic [7:0] BPF_DOC2_TICKS = 8'h08;
    localparam logic [7:0] BPF_SHORT_TICKS = 8'h01;
    localparam logic [7:0] BPF_COC_TICKS = 8'h04;
    // register map
    localparam logic [3:0] BPF_CFG_ADDR = 4'h0;
    localparam logic [3:0] BPF_STAT_ADDR = 4'h4;
    localparam logic [2:0] BPF_CFG_RESET = 3'h2;
    localparam int BPF_CFG_ZV_EN = 0;
    localparam int BPF_CFG_PDN = 1;
    localparam int BPF_CFG_REL_CHG = 2;
    localparam int BPF_ST_OVC = 0;
    localparam int BPF_ST_OD = 1;
    localparam int BPF_ST_DOC = 2;
    localparam int BPF_ST_COC = 3;
    localparam int BPF_ST_PM = 4;
    localparam int BPF_ST_BLK = 6;
    localparam int BPF_ST_CHG = 7;
    localparam int BPF_ST_DIS = 8;
    localparam int BPF_ST_NORM = 9;

    typedef enum logic [1:0] {
        PM_RUN = 2'b00,
        PM_PDN = 2'b01,
        PM_PSV = 2'b10
    } bpf_pm_t;

    typedef struct packed {
        logic [4:0] c_above_ovc_thr;
        logic [4:0] c_above_ovc_rel;
        logic [4:0] c_le_od_thr;
        logic [4:0] c_ge_od_rel;
        logic [4:0] c_le_zero_inh;
        logic cur_ge_doc1;
        logic cur_ge_doc2;
        logic cur_ge_short;
        logic cur_le_coc;
        logic lsn_ge_0p3;
        logic lsn_ge_0p7;
        logic lsn_gt_zero;
        logic lsn_le_third;
        logic lsn_le_doc1;
        logic chg_above_zv;
        logic cap_reached;
        logic psi_high;
        logic psi_low;
    } bpf_cmp_t;

    // counter clears when its condition drops, else climbs per tick to lim
    function automatic logic [7:0] bpf_step(input logic [7:0] cnt, input logic cond, input logic tick,
                                            input logic [7:0] lim);
        if (!cond) begin
            return 8'h00;
        end
        if (tick && cnt != lim) begin
            return cnt + 8'h01;
        end
        return cnt;
    endfunction : bpf_step
endpackage : bpf_pkg

/* pkg/bpf_cmp_if.sv */
interface bpf_cmp_if;
    import bpf_pkg::*;
    bpf_cmp_t raw;
    bpf_cmp_t syncd;
    modport sync (input raw, output syncd);
    modport core (output raw, input syncd);
endinterface : bpf_cmp_if

/* design/bpf_sync.sv */
module bpf_sync
    import bpf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    bpf_cmp_if.sync cmp
);
    typedef struct packed {
        bpf_cmp_t s1;
        bpf_cmp_t s2;
    } bpf_sync_t;

    bpf_sync_t st;
    bpf_sync_t next_st;

    always_comb begin
        next_st.s1 = cmp.raw;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // idle pin levels, so that no false charger or wake edge follows reset
            st <= '{s1: '{lsn_gt_zero: 1'b1, psi_high: 1'b1, default: '0},
                    s2: '{lsn_gt_zero: 1'b1, psi_high: 1'b1, default: '0}};
        end else begin
            st <= next_st;
        end
    end

    assign cmp.syncd = st.s2;
endmodule : bpf_sync

/* design/bpf_top.sv */
module bpf_top
    import bpf_pkg::*;
#(
    parameter logic [12:0] TICK_DIV = BPF_TICK_DIV
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [4:0] cell_above_ovc_thr,
    input wire logic [4:0] cell_above_ovc_rel,
    input wire logic [4:0] cell_le_od_thr,
    input wire logic [4:0] cell_ge_od_rel,
    input wire logic [4:0] cell_le_zero_inh,
    input wire logic cur_ge_doc1,
    input wire logic cur_ge_doc2,
    input wire logic cur_ge_short,
    input wire logic cur_le_coc,
    input wire logic lsn_ge_0p3,
    input wire logic lsn_ge_0p7,
    input wire logic lsn_gt_zero,
    input wire logic lsn_le_third,
    input wire logic lsn_le_doc1,
    input wire logic chg_above_zv,
    input wire logic cap_reached,
    input wire logic psi_high,
    input wire logic psi_low,
    output logic charge_fet_ctrl,
    output logic discharge_fet_ctrl,
    output logic load_sense_pullup_en,
    output logic load_sense_pulldown_en,
    output logic delay_cap_charge_en
);
    typedef struct packed {
        logic [12:0] div;
        logic tick;
        bpf_pm_t pm;
        logic ovc;
        logic od;
        logic doc;
        logic coc;
        logic blk;
        logic [7:0] cnt_ovc;
        logic [7:0] cnt_od;
        logic [7:0] cnt_d2;
        logic [7:0] cnt_sh;
        logic [7:0] cnt_coc;
        logic [2:0] cfg;
        logic [31:0] rdata;
        logic chg;
        logic dis;
        logic pu;
        logic pd;
        logic cap;
    } bpf_state_t;

    bpf_state_t st;
    bpf_state_t next_st;
    bpf_cmp_if cmp_if ();
    bpf_cmp_t c;
    logic run;
    logic any_ovc;
    logic any_od;
    logic zv_block;
    logic doc_trip;
    logic [31:0] status;

    assign cmp_if.raw = '{
        c_above_ovc_thr: cell_above_ovc_thr,
        c_above_ovc_rel: cell_above_ovc_rel,
        c_le_od_thr: cell_le_od_thr,
        c_ge_od_rel: cell_ge_od_rel,
        c_le_zero_inh: cell_le_zero_inh,
        cur_ge_doc1: cur_ge_doc1,
        cur_ge_doc2: cur_ge_doc2,
        cur_ge_short: cur_ge_short,
        cur_le_coc: cur_le_coc,
        lsn_ge_0p3: lsn_ge_0p3,
        lsn_ge_0p7: lsn_ge_0p7,
        lsn_gt_zero: lsn_gt_zero,
        lsn_le_third: lsn_le_third,
        lsn_le_doc1: lsn_le_doc1,
        chg_above_zv: chg_above_zv,
        cap_reached: cap_reached,
        psi_high: psi_high,
        psi_low: psi_low
    };

    bpf_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .cmp(cmp_if.sync)
    );

    assign c = cmp_if.syncd;

    always_comb begin
        status = '0;
        status[BPF_ST_OVC] = st.ovc;
        status[BPF_ST_OD] = st.od;
        status[BPF_ST_DOC] = st.doc;
        status[BPF_ST_COC] = st.coc;
        status[BPF_ST_PM +: 2] = st.pm;
        status[BPF_ST_BLK] = st.blk;
        status[BPF_ST_CHG] = st.chg;
        status[BPF_ST_DIS] = st.dis;
        status[BPF_ST_NORM] = st.chg && st.dis;
    end

    always_comb begin
        next_st = st;
        run = (st.pm == PM_RUN);
        any_ovc = |c.c_above_ovc_thr;
        any_od = |c.c_le_od_thr;
        next_st.tick = 1'b0;
        if (st.div >= TICK_DIV - 13'h0001) begin
            next_st.div = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.div = st.div + 13'h0001;
        end

        // register bus: config is writable, status read-only
        if (reg_wr && reg_addr == BPF_CFG_ADDR) begin
            next_st.cfg = reg_wdata[2:0];
        end
        next_st.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                BPF_CFG_ADDR: next_st.rdata = {29'h0, st.cfg};
                BPF_STAT_ADDR: next_st.rdata = status;
                default: next_st.rdata = '0;
            endcase
        end

        next_st.cnt_ovc = bpf_step(st.cnt_ovc, run && !st.ovc && any_ovc, st.tick, BPF_OVC_TICKS);
        next_st.cnt_od = bpf_step(st.cnt_od, run && !st.od && any_od, st.tick, BPF_OD_TICKS);
        next_st.cnt_d2 = bpf_step(st.cnt_d2, run && !st.doc && c.cur_ge_doc2, st.tick, BPF_DOC2_TICKS);
        next_st.cnt_sh = bpf_step(st.cnt_sh, run && !st.doc && c.cur_ge_doc2, st.tick, BPF_SHORT_TICKS);
        next_st.cnt_coc = bpf_step(st.cnt_coc, run && !st.coc && c.cur_le_coc, st.tick, BPF_COC_TICKS);

        if (run && !st.ovc && any_ovc && st.cnt_ovc == BPF_OVC_TICKS) begin
            next_st.ovc = 1'b1;
        end
        if (run && st.ovc && ((!c.lsn_ge_0p3 && !(|c.c_above_ovc_rel)) || (c.lsn_ge_0p3 && !any_ovc))) begin
            next_st.ovc = 1'b0;
        end

        if (run && !st.od && any_od && st.cnt_od == BPF_OD_TICKS) begin
            next_st.od = 1'b1;
        end
        if (run && st.od && ((!c.lsn_gt_zero && !any_od) || (c.lsn_gt_zero && (&c.c_ge_od_rel)))) begin
            next_st.od = 1'b0;
        end

        doc_trip = 1'b0;
        if (c.cur_ge_doc1 && c.cap_reached) begin
            doc_trip = 1'b1;
        end
        if (c.cur_ge_doc2 && st.cnt_d2 == BPF_DOC2_TICKS) begin
            doc_trip = 1'b1;
        end
        if (c.cur_ge_short && st.cnt_sh == BPF_SHORT_TICKS) begin
            doc_trip = 1'b1;
        end
        if (run && !st.doc && doc_trip) begin
            next_st.doc = 1'b1;
        end
        if (run && st.doc && !st.cfg[BPF_CFG_REL_CHG] && c.lsn_le_third) begin
            next_st.doc = 1'b0;
        end
        if (run && st.doc && st.cfg[BPF_CFG_REL_CHG] && c.lsn_le_doc1) begin
            next_st.doc = 1'b0;
        end

        if (run && !st.coc && c.cur_le_coc && st.cnt_coc == BPF_COC_TICKS) begin
            next_st.coc = 1'b1;
        end
        if (run && st.coc && c.lsn_ge_0p3) begin
            next_st.coc = 1'b0;
        end

        // startup block released by charger or short
        if (run && st.blk && !c.lsn_gt_zero) begin
            next_st.blk = 1'b0;
        end

        case (st.pm)
            PM_RUN: begin
                if (st.cfg[BPF_CFG_PDN] && st.od && st.pu && c.lsn_ge_0p7) begin
                    next_st.pm = PM_PDN;
                end
            end
            PM_PDN: begin
                if (!c.lsn_ge_0p7) begin
                    next_st.pm = PM_RUN;
                end
            end
            PM_PSV: begin
                if (c.psi_high) begin
                    next_st.pm = PM_RUN;
                    next_st.ovc = 1'b0;
                    next_st.od = 1'b0;
                    next_st.doc = 1'b0;
                    next_st.coc = 1'b0;
                    next_st.blk = 1'b0;
                end
            end
            default: next_st.pm = PM_RUN;
        endcase
        if (c.psi_low) begin
            next_st.pm = PM_PSV;
        end

        zv_block = (|c.c_le_zero_inh) && !st.cfg[BPF_CFG_ZV_EN];
        if ((|c.c_le_zero_inh) && st.cfg[BPF_CFG_ZV_EN] && !c.chg_above_zv) begin
            zv_block = 1'b1;
        end

        // outputs follow next state so pins match status in the same cycle
        // flags combine independently
        next_st.chg = (next_st.pm == PM_RUN) && !next_st.ovc && !next_st.coc && !zv_block;
        // both high only when all clear
        next_st.dis = (next_st.pm == PM_RUN) && !next_st.od && !next_st.doc && !next_st.blk;
        next_st.pu = (next_st.pm != PM_PSV) && ((next_st.od && st.cfg[BPF_CFG_PDN]) || next_st.coc
                     || (next_st.doc && st.cfg[BPF_CFG_REL_CHG]));
        next_st.pd = (next_st.pm == PM_RUN) && next_st.doc && !st.cfg[BPF_CFG_REL_CHG];
        // charge delay capacitor on level one
        next_st.cap = (next_st.pm == PM_RUN) && !next_st.doc && c.cur_ge_doc1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '{div: '0, tick: 1'b0, pm: PM_RUN, cfg: BPF_CFG_RESET, blk: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign charge_fet_ctrl = st.chg;
    assign discharge_fet_ctrl = st.dis;
    assign load_sense_pullup_en = st.pu;
    assign load_sense_pulldown_en = st.pd;
    assign delay_cap_charge_en = st.cap;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_normal_outputs: assert property (charge_fet_ctrl && discharge_fet_ctrl |-> st.pm == PM_RUN && !st.ovc
        && !st.od && !st.doc && !st.coc) else $error("both outputs high outside normal");
    a_ovc_detect: assert property (st.pm == PM_RUN && !c.psi_low && !st.ovc && any_ovc
        && st.cnt_ovc == BPF_OVC_TICKS |=> st.ovc && !charge_fet_ctrl) else $error("overcharge missed");
    a_od_output: assert property (st.od |-> !discharge_fet_ctrl) else $error("discharge on in overdischarge");
    a_pdn_entry: assert property (st.pm == PM_RUN && !c.psi_low && st.cfg[BPF_CFG_PDN] && st.od && st.pu
        && c.lsn_ge_0p7 |=> st.pm == PM_PDN && !charge_fet_ctrl) else $error("power-down not entered");
    a_pdn_release: assert property (st.pm == PM_PDN && !c.psi_low && !c.lsn_ge_0p7 |=> st.pm == PM_RUN)
        else $error("power-down not released");
    a_doc_pulls: assert property (st.doc && st.pm == PM_RUN |-> (load_sense_pulldown_en != st.cfg[BPF_CFG_REL_CHG])
        && (load_sense_pullup_en == st.cfg[BPF_CFG_REL_CHG] || st.od)) else $error("wrong release pulls");
    a_coc_release: assert property (st.pm == PM_RUN && !c.psi_low && st.coc && c.lsn_ge_0p3 |=> !st.coc)
        else $error("charge overcurrent not released");
    a_psv_outputs: assert property (st.pm == PM_PSV |-> !charge_fet_ctrl && !discharge_fet_ctrl)
        else $error("outputs on in power saving");
    a_psv_exit: assert property (st.pm == PM_PSV && c.psi_high && !c.psi_low |=> st.pm == PM_RUN && !st.ovc
        && !st.od && !st.doc && !st.coc) else $error("power saving exit not normal");
    a_cnt_clear: assert property (!any_ovc |=> st.cnt_ovc == 8'h00) else $error("delay counter kept");
    a_tick_gap: assert property (st.tick |=> !st.tick) else $error("tick too fast");
    a_ovc_release: assert property (run && !c.psi_low && st.ovc && !c.lsn_ge_0p3 && !(|c.c_above_ovc_rel)
        |=> !st.ovc) else $error("overcharge not released");
    a_od_release: assert property (run && !c.psi_low && st.od && c.lsn_gt_zero && (&c.c_ge_od_rel)
        |=> !st.od) else $error("overdischarge not released");
    a_doc_level1: assert property (run && !c.psi_low && !st.doc && c.cur_ge_doc1 && c.cap_reached
        |=> st.doc && !discharge_fet_ctrl) else $error("level one trip missed");
    a_short_trip: assert property (run && !c.psi_low && !st.doc && c.cur_ge_short && st.cnt_sh == BPF_SHORT_TICKS
        |=> st.doc) else $error("short trip missed");
    a_cap_charge: assert property (run && !c.psi_low && !st.doc && c.cur_ge_doc1
        |=> delay_cap_charge_en || st.doc || st.pm != PM_RUN) else $error("capacitor not charged");
    a_coc_detect: assert property (run && !c.psi_low && !st.coc && c.cur_le_coc && st.cnt_coc == BPF_COC_TICKS
        |=> st.coc && !charge_fet_ctrl && load_sense_pullup_en) else $error("charge overcurrent missed");
    a_zv_inhibit: assert property (!st.cfg[BPF_CFG_ZV_EN] && (|c.c_le_zero_inh) |=> !charge_fet_ctrl)
        else $error("charge on with empty cell");
    a_blk_release: assert property (run && !c.psi_low && st.blk && !c.lsn_gt_zero |=> !st.blk)
        else $error("startup block kept");
    a_both_off: assert property (st.ovc && st.od |-> !charge_fet_ctrl && !discharge_fet_ctrl)
        else $error("mixed cells left an output on");

    c_both_flags: cover property (st.ovc && st.od);
    c_pdn: cover property (st.pm == PM_PDN);
    c_doc: cover property ($rose(st.doc));
    c_coc_release: cover property ($fell(st.coc));
endmodule : bpf_top

/* verif/bpf_far_side.sv */
// cells, load, charger, delay capacitor and control pin, reduced to comparator results
module bpf_far_side
    import bpf_pkg::*;
#(
    parameter int CAP_CYC = 200
) (
    input wire logic sys_clk,
    input int cell_mv [5],
    input int cur_mv,
    input int psi_mv,
    input wire logic load_on,
    input wire logic chg_on,
    input wire logic pu_en,
    input wire logic pd_en,
    input wire logic cap_en,
    output bpf_cmp_t cmp
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SUPPLY = 18500;
    int node;
    int cap_cnt = 0;
    // charger drags the node below ground; a load or the pull-up lifts it to supply
    always_comb node = chg_on ? -500 : (load_on || pu_en) ? SUPPLY : pd_en ? 0 : 100;
    // capacitor ramps only while charged, discharged at once otherwise
    always_ff @(posedge sys_clk) cap_cnt <= cap_en ? cap_cnt + 1 : 0;
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            cmp.c_above_ovc_thr[i] = cell_mv[i] > 4200;
            cmp.c_above_ovc_rel[i] = cell_mv[i] > 4100;
            cmp.c_le_od_thr[i] = cell_mv[i] <= 2500;
            cmp.c_ge_od_rel[i] = cell_mv[i] >= 2900;
            cmp.c_le_zero_inh[i] = cell_mv[i] <= 1000;
        end
        cmp.cur_ge_doc1 = cur_mv >= 100;
        cmp.cur_ge_doc2 = cur_mv >= 200;
        cmp.cur_ge_short = cur_mv >= 300;
        cmp.cur_le_coc = cur_mv <= -100;
        cmp.lsn_ge_0p3 = node >= 300;
        cmp.lsn_ge_0p7 = node >= 700;
        cmp.lsn_gt_zero = node > 0;
        cmp.lsn_le_third = node <= SUPPLY / 3;
        cmp.lsn_le_doc1 = node <= 100;
        cmp.chg_above_zv = chg_on;
        cmp.cap_reached = cap_cnt >= CAP_CYC;
        cmp.psi_high = psi_mv > 2000;
        cmp.psi_low = psi_mv < 500;
    end
endmodule : bpf_far_side

/* verif/tb_top.sv */
module tb_top
    import bpf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] ST_RUN = (32'h1 << BPF_ST_CHG) | (32'h1 << BPF_ST_DIS) | (32'h1 << BPF_ST_NORM);
    localparam logic [31:0] ST_BOOT = (32'h1 << BPF_ST_CHG) | (32'h1 << BPF_ST_BLK);
    localparam logic [31:0] ST_PDN = (32'h1 << BPF_ST_OD) | (32'(PM_PDN) << BPF_ST_PM);
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic chg, dis, pu, pd, cap;
    logic [4:0] outs;
    int cell_mv [5] = '{5{3700}};
    int cur_mv = 0;
    int psi_mv = 3000;
    logic load_on = 1'b0;
    logic chg_on = 1'b0;
    bpf_cmp_t cmp;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    assign outs = {cap, pd, pu, dis, chg};
    always #20 sys_clk = ~sys_clk;

    // tick every 8 cycles: all timing windows below assume this
    bpf_top #(.TICK_DIV(13'h008)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cell_above_ovc_thr(cmp.c_above_ovc_thr), .cell_above_ovc_rel(cmp.c_above_ovc_rel),
        .cell_le_od_thr(cmp.c_le_od_thr), .cell_ge_od_rel(cmp.c_ge_od_rel),
        .cell_le_zero_inh(cmp.c_le_zero_inh), .cur_ge_doc1(cmp.cur_ge_doc1),
        .cur_ge_doc2(cmp.cur_ge_doc2), .cur_ge_short(cmp.cur_ge_short), .cur_le_coc(cmp.cur_le_coc),
        .lsn_ge_0p3(cmp.lsn_ge_0p3), .lsn_ge_0p7(cmp.lsn_ge_0p7), .lsn_gt_zero(cmp.lsn_gt_zero),
        .lsn_le_third(cmp.lsn_le_third), .lsn_le_doc1(cmp.lsn_le_doc1),
        .chg_above_zv(cmp.chg_above_zv), .cap_reached(cmp.cap_reached),
        .psi_high(cmp.psi_high), .psi_low(cmp.psi_low), .charge_fet_ctrl(chg),
        .discharge_fet_ctrl(dis), .load_sense_pullup_en(pu), .load_sense_pulldown_en(pd),
        .delay_cap_charge_en(cap)
    );
    bpf_far_side #(.CAP_CYC(200)) i_far (
        .sys_clk(sys_clk), .cell_mv(cell_mv), .cur_mv(cur_mv), .psi_mv(psi_mv), .load_on(load_on),
        .chg_on(chg_on), .pu_en(pu), .pd_en(pd), .cap_en(cap), .cmp(cmp)
    );

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // output w must reach v no sooner than lo and no later than hi cycles
    task automatic expect_out(input int w, input logic v, input int lo, input int hi);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (outs[w] !== v && n < hi);
        check($sformatf("out%0d level", w), {31'h0, v}, {31'h0, outs[w]});
        check($sformatf("out%0d early at %0d", w, n), 32'h1, {31'h0, n >= lo});
    endtask : expect_out

    task automatic stay(input int w, input logic v, input int n);
        logic ok;
        ok = 1'b1;
        repeat (n) begin
            @(negedge sys_clk);
            ok &= (outs[w] === v);
        end
        check($sformatf("out%0d steady", w), 32'h1, {31'h0, ok});
    endtask : stay

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_check(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        check(what, exp, reg_rdata);
    endtask : reg_check

    task automatic t_reset();
        repeat (10) @(posedge sys_clk);
        reg_check(BPF_CFG_ADDR, {29'h0, BPF_CFG_RESET}, "cfg reset");
        reg_write(BPF_STAT_ADDR, 32'hFFFF_FFFF);
        reg_check(BPF_STAT_ADDR, ST_BOOT, "status startup");
        reg_check(4'h8, 32'h0, "unmapped read");
        @(posedge sys_clk);
        chg_on <= 1'b1;
        expect_out(1, 1'b1, 0, 12);
        @(posedge sys_clk);
        chg_on <= 1'b0;
        reg_check(BPF_STAT_ADDR, ST_RUN, "status normal");
    endtask : t_reset

    task automatic t_ovc();
        @(posedge sys_clk);
        cell_mv[2] <= 4300;
        repeat (60) @(posedge sys_clk);
        cell_mv[2] <= 3700;
        repeat (4) @(posedge sys_clk);
        cell_mv[2] <= 4300;
        expect_out(0, 1'b0, 118, 160);
        @(posedge sys_clk);
        cell_mv[2] <= 4150;
        stay(0, 1'b0, 20);
        @(posedge sys_clk);
        load_on <= 1'b1;
        expect_out(0, 1'b1, 0, 12);
        @(posedge sys_clk);
        load_on <= 1'b0;
        cell_mv[2] <= 3700;
    endtask : t_ovc

    task automatic t_od();
        @(posedge sys_clk);
        cell_mv[0] <= 2400;
        expect_out(1, 1'b0, 118, 160);
        expect_out(2, 1'b1, 0, 4);
        expect_out(0, 1'b0, 0, 10);
        reg_check(BPF_STAT_ADDR, ST_PDN, "status power-down");
        @(posedge sys_clk);
        cell_mv[0] <= 2700;
        stay(1, 1'b0, 20);
        @(posedge sys_clk);
        chg_on <= 1'b1;
        expect_out(1, 1'b1, 0, 12);
        expect_out(0, 1'b1, 0, 4);
        @(posedge sys_clk);
        chg_on <= 1'b0;
        cell_mv[0] <= 3700;
    endtask : t_od

    task automatic t_doc();
        @(posedge sys_clk);
        load_on <= 1'b1;
        cur_mv <= 150;
        expect_out(4, 1'b1, 0, 6);
        expect_out(1, 1'b0, 190, 215);
        expect_out(3, 1'b1, 0, 4);
        check("pull-up in load release", 32'h0, {31'h0, pu});
        @(posedge sys_clk);
        cur_mv <= 0;
        stay(1, 1'b0, 20);
        @(posedge sys_clk);
        load_on <= 1'b0;
        expect_out(1, 1'b1, 0, 12);
        reg_write(BPF_CFG_ADDR, (32'h1 << BPF_CFG_PDN) | (32'h1 << BPF_CFG_REL_CHG));
        @(posedge sys_clk);
        load_on <= 1'b1;
        cur_mv <= 250;
        expect_out(1, 1'b0, 55, 85);
        expect_out(2, 1'b1, 0, 4);
        check("pull-down in charger release", 32'h0, {31'h0, pd});
        @(posedge sys_clk);
        cur_mv <= 0;
        load_on <= 1'b0;
        stay(1, 1'b0, 20);
        @(posedge sys_clk);
        chg_on <= 1'b1;
        expect_out(1, 1'b1, 0, 12);
        @(posedge sys_clk);
        chg_on <= 1'b0;
        cur_mv <= 350;
        expect_out(1, 1'b0, 2, 16);
        @(posedge sys_clk);
        cur_mv <= 0;
        chg_on <= 1'b1;
        expect_out(1, 1'b1, 0, 12);
        @(posedge sys_clk);
        chg_on <= 1'b0;
        reg_write(BPF_CFG_ADDR, {29'h0, BPF_CFG_RESET});
    endtask : t_doc

    task automatic t_coc();
        @(posedge sys_clk);
        chg_on <= 1'b1;
        cur_mv <= -150;
        expect_out(0, 1'b0, 24, 50);
        expect_out(2, 1'b1, 0, 4);
        @(posedge sys_clk);
        cur_mv <= 0;
        stay(0, 1'b0, 20);
        @(posedge sys_clk);
        chg_on <= 1'b0;
        expect_out(0, 1'b1, 0, 12);
    endtask : t_coc

    task automatic t_psv();
        @(posedge sys_clk);
        psi_mv <= 0;
        expect_out(1, 1'b0, 0, 6);
        expect_out(0, 1'b0, 0, 2);
        @(posedge sys_clk);
        psi_mv <= 1000;
        stay(1, 1'b0, 12);
        @(posedge sys_clk);
        psi_mv <= 3000;
        expect_out(1, 1'b1, 0, 10);
        reg_check(BPF_STAT_ADDR, ST_RUN, "status after wake");
    endtask : t_psv

    task automatic t_zv();
        @(posedge sys_clk);
        cell_mv[4] <= 900;
        expect_out(0, 1'b0, 0, 8);
        reg_write(BPF_CFG_ADDR, (32'h1 << BPF_CFG_PDN) | (32'h1 << BPF_CFG_ZV_EN));
        stay(0, 1'b0, 4);
        @(posedge sys_clk);
        chg_on <= 1'b1;
        expect_out(0, 1'b1, 0, 8);
        @(posedge sys_clk);
        chg_on <= 1'b0;
        cell_mv[4] <= 3700;
    endtask : t_zv

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // whole run needs about 900 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        repeat (19) @(posedge sys_clk);
        @(negedge sys_clk);
        check("outputs in reset", 32'h0, {27'h0, outs});
        @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_ovc();
        t_od();
        t_doc();
        t_coc();
        t_psv();
        t_zv();
        complete_run();
    end
endmodule : tb_top
